// ==== hdl/pmtr_pkg.sv ====
// Types shared by the table read path and its program memory.
// Assumes the constants header is on the include path.
`include "pmtr_regs.svh"

package pmtr_pkg;

  // --------------------------------------------------------------------------
  // Commands from instruction decode
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMTR_RD_STD      = 2'h0,
    PMTR_RD_STD_LAST = 2'h1,
    PMTR_RD_EXT      = 2'h2,
    PMTR_RD_EXT_LAST = 2'h3
  } pmtr_kind_t;

  typedef struct packed {
    logic                   valid;
    pmtr_kind_t             kind;
    logic [`PMTR_DM_AW-1:0] dest;
  } pmtr_cmd_t;

  // Data memory write towards the core
  typedef struct packed {
    logic                   we;
    logic [`PMTR_DM_AW-1:0] addr;
    logic [7:0]             data;
  } pmtr_dm_wr_t;

  // Core access to the pointer and holding registers
  typedef struct packed {
    logic       wr;
    logic [1:0] sel;
    logic [7:0] wdata;
  } pmtr_sfr_t;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMTR_IDLE = 2'b01,
    PMTR_XFER = 2'b10
  } pmtr_fsm_t;

  typedef struct packed {
    pmtr_fsm_t              fsm;
    logic [7:0]             ptr_low;
    logic [7:0]             ptr_high;
    logic [7:0]             hold;
    logic [`PMTR_DM_AW-1:0] dest;
    logic                   busy;
    pmtr_dm_wr_t            dm_wr;
    logic [7:0]             sfr_rdata;
  } pmtr_state_t;

endpackage : pmtr_pkg

// ==== hdl/pmtr_prog_mem.sv ====
// Program memory of 8K 16-bit words with a registered read port.
// Assumes a loader outside fills it through the write port.
`timescale 1ns/1ps

module pmtr_prog_mem
  import pmtr_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Read port
  input  wire logic [`PMTR_PM_AW-1:0]  rd_addr,
  output logic      [`PMTR_PM_DW-1:0]  rd_data,
  // Load port
  input  wire logic                    wr_en,
  input  wire logic [`PMTR_PM_AW-1:0]  wr_addr,
  input  wire logic [`PMTR_PM_DW-1:0]  wr_data
);

  logic [`PMTR_PM_DW-1:0] mem [0:`PMTR_PM_WORDS-1];

  // Registered read, write-first is not promised on address clash
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr]; // RQ1
  end

endmodule : pmtr_prog_mem

// ==== hdl/pmtr_regs.svh ====
// Constants of the program memory table read path.
// Assumes inclusion by bare name from the package and the bench.
// Functional notes
// RQ1: Word address comes from pointer low and high; fetch from 8K-word program memory.
// RQ2: Pointer low is offset within the page that pointer high selects.
// RQ3: Every table read copies the fetched upper byte into the holding register.
// RQ4: Holding register is readable and writable through the core register port.
// RQ5: Each table instruction occupies two cycles; busy stalls the core meanwhile.
// RQ6: Last-page forms use page 1F00H and ignore pointer high.
// RQ7: Lower byte of the fetched word is written to the named data location.
// RQ8: Standard forms write into sector 0, extended forms into any sector.
// RQ9: A table read leaves both pointer registers unchanged.
`ifndef PMTR_REGS_SVH
`define PMTR_REGS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define PMTR_PM_WORDS     8192
`define PMTR_PM_AW        13
`define PMTR_PM_DW        16
`define PMTR_PAGE_W       5
`define PMTR_DM_AW        10
`define PMTR_SECTOR_W     2
`define PMTR_LAST_PAGE    5'h1F
`define PMTR_SECTOR0      2'h0

// ----------------------------------------------------------------------------
// Core register port selections and reset values
// ----------------------------------------------------------------------------
`define PMTR_SEL_PTR_LOW  2'h0
`define PMTR_SEL_PTR_HIGH 2'h1
`define PMTR_SEL_HOLD     2'h2
`define PMTR_RST_BYTE     8'h00

`endif

// ==== hdl/pmtr_table_read.sv ====
// Table read path: pointer registers, holding register and fetch sequencer.
// Assumes the core stalls while busy and accepts one data write per read.
`timescale 1ns/1ps

module pmtr_table_read
  import pmtr_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Command from instruction decode
  input  wire pmtr_cmd_t               cmd,
  output logic                         busy,
  // Data memory write
  output pmtr_dm_wr_t                  dm_wr,
  // Core register port
  input  wire pmtr_sfr_t               sfr,
  output logic [7:0]                   sfr_rdata,
  // Program memory load
  input  wire logic                    pm_wr_en,
  input  wire logic [`PMTR_PM_AW-1:0]  pm_wr_addr,
  input  wire logic [`PMTR_PM_DW-1:0]  pm_wr_data
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------

  // Page selection, the last-page forms never look at pointer high
  function automatic logic [`PMTR_PM_AW-1:0] word_addr(input pmtr_kind_t k,
                                                      input logic [7:0] lo,
                                                      input logic [7:0] hi);
    logic [`PMTR_PAGE_W-1:0] page;
    page = hi[`PMTR_PAGE_W-1:0];
    if (k == PMTR_RD_STD_LAST || k == PMTR_RD_EXT_LAST) begin
      page = `PMTR_LAST_PAGE; // RQ6
    end
    word_addr = {page, lo}; // RQ2
  endfunction : word_addr

  // Standard forms reach sector 0 only
  function automatic logic [`PMTR_DM_AW-1:0] dest_addr(input pmtr_kind_t k,
                                                      input logic [`PMTR_DM_AW-1:0] d);
    if (k == PMTR_RD_STD || k == PMTR_RD_STD_LAST) begin
      dest_addr = {`PMTR_SECTOR0, d[`PMTR_DM_AW-`PMTR_SECTOR_W-1:0]}; // RQ8
    end else begin
      dest_addr = d; // RQ8
    end
  endfunction : dest_addr

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pmtr_state_t              st;
  pmtr_state_t              next_st;
  logic [`PMTR_PM_AW-1:0]   pm_rd_addr;
  logic [`PMTR_PM_DW-1:0]   pm_rd_data;
  logic                     accept;

  localparam pmtr_state_t ST_RESET = '{
    fsm:       PMTR_IDLE,
    ptr_low:   `PMTR_RST_BYTE,
    ptr_high:  `PMTR_RST_BYTE,
    hold:      `PMTR_RST_BYTE,
    dest:      '0,
    busy:      1'b0,
    dm_wr:     '0,
    sfr_rdata: `PMTR_RST_BYTE
  };

  // Fetch address formed straight from the live pointers in the accept cycle
  assign accept     = cmd.valid && (st.fsm == PMTR_IDLE);
  assign pm_rd_addr = word_addr(cmd.kind, st.ptr_low, st.ptr_high); // RQ1

  pmtr_prog_mem u_mem (
    .clk     (clk),
    .rd_addr (pm_rd_addr),
    .rd_data (pm_rd_data),
    .wr_en   (pm_wr_en),
    .wr_addr (pm_wr_addr),
    .wr_data (pm_wr_data)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.dm_wr.we = 1'b0;

    // Core writes to the pointers and holding register
    if (sfr.wr) begin
      case (sfr.sel)
        `PMTR_SEL_PTR_LOW:  next_st.ptr_low  = sfr.wdata;
        `PMTR_SEL_PTR_HIGH: next_st.ptr_high = sfr.wdata;
        `PMTR_SEL_HOLD:     next_st.hold     = sfr.wdata; // RQ4
        default:            next_st.hold     = st.hold;
      endcase
    end

    // Sequencer; pointers are touched only by the illegal-state reset
    case (st.fsm)
      PMTR_IDLE: begin
        if (accept) begin
          next_st.fsm  = PMTR_XFER;
          next_st.busy = 1'b1; // RQ5
          next_st.dest = dest_addr(cmd.kind, cmd.dest); // RQ8
        end
      end
      PMTR_XFER: begin
        // Memory word is ready; hardware load beats a same-cycle core write
        next_st.fsm        = PMTR_IDLE;
        next_st.busy       = 1'b0; // RQ5
        next_st.dm_wr.we   = 1'b1; // RQ7
        next_st.dm_wr.addr = st.dest; // RQ7
        next_st.dm_wr.data = pm_rd_data[7:0]; // RQ7
        next_st.hold       = pm_rd_data[15:8]; // RQ3
      end
      default: begin
        next_st = ST_RESET;
      end
    endcase

    // Read-back of the register port, registered one cycle
    case (sfr.sel)
      `PMTR_SEL_PTR_LOW:  next_st.sfr_rdata = next_st.ptr_low;
      `PMTR_SEL_PTR_HIGH: next_st.sfr_rdata = next_st.ptr_high;
      `PMTR_SEL_HOLD:     next_st.sfr_rdata = next_st.hold; // RQ4
      default:            next_st.sfr_rdata = `PMTR_RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign busy      = st.busy;
  assign dm_wr     = st.dm_wr;
  assign sfr_rdata = st.sfr_rdata;

endmodule : pmtr_table_read

// ==== verification/pmtr_core_model.sv ====
// Data memory side of the core: stores and counts table read writes.
// Assumes one write pulse per accepted read.
`timescale 1ns/1ps

module pmtr_core_model
  import pmtr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Write from the table read path
  input  wire pmtr_dm_wr_t dm_wr,
  output int unsigned      wr_seen
);
  logic [7:0] dmem [1024];

  // Count lets the bench spot lost or doubled writes
  always_ff @(posedge clk) begin
    if (reset) wr_seen <= 0;
    else if (dm_wr.we) begin
      dmem[dm_wr.addr] <= dm_wr.data;
      wr_seen          <= wr_seen + 1;
    end
  end
endmodule : pmtr_core_model

// ==== verification/pmtr_table_read_chk.sv ====
// Checker for the table read path, bound to its top module.
// Assumes the design ports as declared in the package.
`timescale 1ns/1ps

module pmtr_table_read_chk
  import pmtr_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Watched ports
  input wire pmtr_cmd_t   cmd,
  input wire logic        busy,
  input wire pmtr_dm_wr_t dm_wr,
  input wire pmtr_sfr_t   sfr,
  input wire logic [7:0]  sfr_rdata
);
  // ---------------------------------------------------------------------------
  // Properties, all on the one system clock
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  accept_busy_a: assert property (cmd.valid && !busy |=> busy)
    else $error("busy missing after accepted read");
  busy_single_a: assert property (busy |=> !busy)
    else $error("busy longer than one cycle");
  write_follows_a: assert property (busy |=> dm_wr.we)
    else $error("no data write after busy");
  write_cause_a: assert property (dm_wr.we |-> $past(busy))
    else $error("data write without a read");
  std_sector_a: assert property (cmd.valid && !busy && !cmd.kind[1] |-> ##2
    dm_wr.addr == {2'h0, $past(cmd.dest[7:0], 2)}) else $error("standard read left sector 0");
  ext_dest_a: assert property (cmd.valid && !busy && cmd.kind[1] |-> ##2
    dm_wr.addr == $past(cmd.dest, 2)) else $error("extended read destination wrong");
  sfr_write_a: assert property (sfr.wr && sfr.sel != 2'h3 && !(busy && sfr.sel == 2'h2)
    |=> sfr_rdata == $past(sfr.wdata)) else $error("register write not read back");
  ptr_stable_a: assert property (!sfr.wr && !sfr.sel[1] ##1 !sfr.wr && $stable(sfr.sel)
    |=> $stable(sfr_rdata)) else $error("pointer changed without a write");

  // Main scenarios reached
  cover property (cmd.valid && busy);
  cover property (dm_wr.we && sfr.sel == 2'h2);
  cover property (sfr.wr && sfr.sel == 2'h3);
endmodule : pmtr_table_read_chk

bind pmtr_table_read pmtr_table_read_chk pmtr_table_read_chk_inst (.clk(clk), .reset(reset), .cmd(cmd),
  .busy(busy), .dm_wr(dm_wr), .sfr(sfr), .sfr_rdata(sfr_rdata));

// ==== verification/tb_top.sv ====
// Self-checking bench for the table read path.
// Assumes the design, the core model and the checker are compiled before it.
`timescale 1ns/1ps
`include "pmtr_regs.svh"

module tb_top;
  import pmtr_pkg::*;
  logic                   clk        = 1'b0;
  logic                   reset      = 1'b1;
  pmtr_cmd_t              cmd        = '0;
  pmtr_sfr_t              sfr        = '0;
  logic                   pm_wr_en   = 1'b0;
  logic [`PMTR_PM_AW-1:0] pm_wr_addr = '0;
  logic [`PMTR_PM_DW-1:0] pm_wr_data = '0;
  logic                   busy;
  pmtr_dm_wr_t            dm_wr;
  logic [7:0]             sfr_rdata, pl, ph;
  int unsigned            wr_seen;
  int                     fail_count = 0;
  int                     checks_done = 0;
  logic [15:0]            mem [int];

  always #10 clk = ~clk;

  pmtr_table_read pmtr_table_read_inst (.clk(clk), .reset(reset), .cmd(cmd), .busy(busy), .dm_wr(dm_wr),
    .sfr(sfr), .sfr_rdata(sfr_rdata), .pm_wr_en(pm_wr_en), .pm_wr_addr(pm_wr_addr), .pm_wr_data(pm_wr_data));
  pmtr_core_model pmtr_core_model_inst (.clk(clk), .reset(reset), .dm_wr(dm_wr), .wr_seen(wr_seen));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  // Register port access; read data lands one edge later
  task automatic sfr_op(input logic w, input logic [1:0] s, input logic [7:0] d);
    sfr = '{w, s, d};
    step();
    sfr.wr = 1'b0;
  endtask : sfr_op

  // One table read against a freshly loaded random word
  task automatic rd(input pmtr_kind_t k, input logic [9:0] d);
    logic [12:0] a;
    logic [15:0] w;
    a = {k[0] ? 5'h1F : ph[4:0], pl};
    w = 16'($urandom);
    pm_wr_en = 1'b1; pm_wr_addr = a; pm_wr_data = w;
    step();
    pm_wr_en = 1'b0;
    mem[a] = w;
    sfr = '{1'b0, 2'h2, 8'h00};
    cmd = '{1'b1, k, d};
    step();
    cmd.valid = 1'b0;
    cmp(16'(busy), 16'h1);
    step();
    cmp(16'(busy), 16'h0);
    cmp(16'(dm_wr.we), 16'h1);
    cmp(16'(dm_wr.data), 16'(mem[a][7:0]));
    cmp(16'(dm_wr.addr), 16'(k[1] ? d : {2'h0, d[7:0]}));
    cmp(16'(sfr_rdata), 16'(mem[a][15:8]));
    // Write pulse must be gone and the low byte stored in the core's memory
    step();
    cmp(16'(dm_wr.we), 16'h0);
    cmp(16'(pmtr_core_model_inst.dmem[k[1] ? d : {2'h0, d[7:0]}]), 16'(mem[a][7:0]));
  endtask : rd

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    int unsigned n;
    void'($urandom(32'h4635));
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    for (int s = 0; s < 4; s++) begin
      pl = 8'($urandom);
      sfr_op(1'b1, 2'(s), pl);
      cmp(16'(sfr_rdata), 16'(s == 3 ? 8'h00 : pl));
    end
    for (int i = 0; i < 8; i++) begin
      pl = 8'($urandom);
      ph = 8'($urandom);
      sfr_op(1'b1, 2'h0, pl);
      sfr_op(1'b1, 2'h1, ph);
      rd(pmtr_kind_t'(i[1:0]), 10'($urandom));
      sfr_op(1'b0, 2'h0, 8'h00);
      cmp(16'(sfr_rdata), 16'(pl));
      sfr_op(1'b0, 2'h1, 8'h00);
      cmp(16'(sfr_rdata), 16'(ph));
      pl = pl - 8'h01;
      sfr_op(1'b1, 2'h0, pl);
      rd(pmtr_kind_t'(i[1:0]), 10'($urandom));
    end
    // Request held into the busy cycle must give one read only
    sfr = '{1'b0, 2'h0, 8'h00};
    n = wr_seen;
    cmd.valid = 1'b1;
    repeat (2) step();
    cmd.valid = 1'b0;
    repeat (3) step();
    cmp(16'(wr_seen - n), 16'h1);
    cmp(16'(wr_seen), 16'd17);
    conclude();
  end

  // About 120 cycles expected; 5000 allowed
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule : tb_top
